// *** scmc_top.sv ***
// serial channel mode control: registers, mode decode, gating and irq
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top
    import scmc_pkg::*;
#(
    parameter int ADDR_W = 8 // apb address width
) (
    input wire logic clock_i, // system clock, 25 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb access phase
    input wire logic pwrite_i, // apb direction
    input wire logic [ADDR_W-1:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error, unmapped address
    input wire logic timer_output_i, // timer output pulse
    input wire logic baud_tick_i, // baud generator pulse
    input wire logic serial_clock_pin_i, // serial clock pin level
    output logic serial_clock_pin_o, // serial clock drive value
    output logic serial_clock_pin_oe_o, // serial clock drive enable
    input wire logic clear_to_send_pin_n_i, // clear to send, low active
    input wire logic rx_frame_done_i, // shifter received a frame
    input wire logic rx_ninth_i, // ninth bit of that frame
    input wire logic tx_frame_done_i, // shifter finished a frame
    output logic xfer_tick_o, // selected transfer clock pulse
    output logic [3:0] frame_bits_o, // data bits per frame
    output logic tx_ninth_bit_o, // ninth bit to transmit
    output logic tx_allow_o, // shifter may start sending
    output logic rx_enable_o, // shifter may receive
    output logic [1:0] fifo_cfg_o, // fifo direction setup
    output logic irq_o // interrupt, level high
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] mode_a_r;
    logic [7:0] mode_b_r;
    logic [2:0] ctrl_r;
    logic [1:0] int_stat_r;
    logic [1:0] int_mask_r;
    logic rx_bit_eight_r;
    logic sclk_d_r;
    logic sclk_out_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    scmc_mode_t mode;
    scmc_clk_src_t clk_src;
    scmc_duplex_t duplex;
    logic is_async, clock_dir, tx_en, rx_en, gap_apply, gap_busy;
    logic sclk_rise, int_clk_rise, cts_ok, dpx_tx_ok, dpx_rx_ok;
    logic rx_evt, tx_evt, wr_en, setup;
    logic [1:0] w1c;

    assign mode = scmc_mode_t'(mode_a_r[`SCMC_A_MODE_HI:`SCMC_A_MODE_LO]);
    assign clk_src =
        scmc_clk_src_t'(mode_a_r[`SCMC_A_CSRC_HI:`SCMC_A_CSRC_LO]);
    assign duplex = scmc_duplex_t'(mode_b_r[`SCMC_B_DPX_HI:`SCMC_B_DPX_LO]);
    assign is_async = (mode != SCMC_IO);
    assign clock_dir = ctrl_r[`SCMC_C_CLK_DIR];
    assign tx_en = mode_b_r[`SCMC_B_TX_EN];
    assign rx_en = mode_a_r[`SCMC_A_RX_EN];

    // frame length per mode; io mode shifts plain bytes
    always_comb begin
        unique case (mode)
            SCMC_IO: frame_bits_o = 4'h8;
            SCMC_UART7: frame_bits_o = 4'h7;
            SCMC_UART8: frame_bits_o = 4'h8;
            SCMC_UART9: frame_bits_o = 4'h9;
        endcase
    end

    // ------------------------------------------------------------------
    // transfer clock selection
    // ------------------------------------------------------------------
    // pin is synchronous to clock_i, so one delay stage finds its edge;
    // no reset, so a pin idling high shows no false edge after reset
    always_ff @(posedge clock_i) begin
        sclk_d_r <= serial_clock_pin_i;
    end

    assign sclk_rise = serial_clock_pin_i && !sclk_d_r;

    // io clock output: half period per baud tick, parked low when idle
    always_ff @(posedge clock_i) begin
        if (rst_i || is_async || clock_dir || !(tx_en || rx_en)) begin
            sclk_out_r <= 1'b0;
        end else if (baud_tick_i) begin
            sclk_out_r <= !sclk_out_r;
        end
    end

    assign int_clk_rise = baud_tick_i && !sclk_out_r && !clock_dir;
    assign serial_clock_pin_o = sclk_out_r;
    assign serial_clock_pin_oe_o = !is_async && !clock_dir;

    always_comb begin
        if (is_async) begin
            unique case (clk_src)
                SCMC_CLK_TIMER: xfer_tick_o = timer_output_i;
                SCMC_CLK_BAUD: xfer_tick_o = baud_tick_i;
                SCMC_CLK_SYS: xfer_tick_o = 1'b1;
                SCMC_CLK_PIN: xfer_tick_o = sclk_rise;
            endcase
        end else if (clock_dir) begin
            xfer_tick_o = sclk_rise;
        end else begin
            xfer_tick_o = int_clk_rise && (tx_en || rx_en);
        end
    end

    // ------------------------------------------------------------------
    // direction, handshake and gap gating
    // ------------------------------------------------------------------
    assign dpx_tx_ok = is_async || duplex == SCMC_DPX_TX
        || duplex == SCMC_DPX_FULL;
    assign dpx_rx_ok = is_async || duplex == SCMC_DPX_RX
        || duplex == SCMC_DPX_FULL;
    assign cts_ok = !(is_async && mode_a_r[`SCMC_A_HS_EN])
        || !clear_to_send_pin_n_i;
    assign tx_allow_o = tx_en && cts_ok && dpx_tx_ok && !gap_busy;
    assign rx_enable_o = rx_en && dpx_rx_ok;
    assign fifo_cfg_o = ctrl_r[`SCMC_C_FIFO_EN]
        ? mode_b_r[`SCMC_B_DPX_HI:`SCMC_B_DPX_LO] : 2'h0;
    assign tx_ninth_bit_o = (mode == SCMC_UART9)
        && mode_a_r[`SCMC_A_TX_NINTH];

    // gap only counts when this block makes the clock and data is queued
    assign gap_apply = !is_async && !clock_dir
        && (ctrl_r[`SCMC_C_DBUF_EN] || ctrl_r[`SCMC_C_FIFO_EN]);

    scmc_gap_timer u_gap (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(gap_apply),
        .start_i(tx_frame_done_i),
        .tick_i(xfer_tick_o),
        .interval_i(mode_b_r[`SCMC_B_GAP_HI:`SCMC_B_GAP_LO]),
        .busy_o(gap_busy)
    );

    // ------------------------------------------------------------------
    // receive ninth bit capture
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rx_bit_eight_r <= 1'b0;
        end else if (rx_frame_done_i && mode == SCMC_UART9) begin
            rx_bit_eight_r <= rx_ninth_i;
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;
    assign prdata_o = prdata_r;
    assign pslverr_o = pslverr_r && psel_i && penable_i;

    // read data is captured in the setup cycle so the access needs no wait
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            unique case (paddr_i)
                `SCMC_OFF_MODE_A: prdata_r[7:0] <= mode_a_r;
                `SCMC_OFF_MODE_B: prdata_r[7:0] <= mode_b_r;
                `SCMC_OFF_INT_STAT: prdata_r[1:0] <= int_stat_r;
                `SCMC_OFF_INT_MASK: prdata_r[1:0] <= int_mask_r;
                `SCMC_OFF_CTRL: prdata_r[2:0] <= ctrl_r;
                `SCMC_OFF_STAT: prdata_r[3:0] <= {mode_a_r[3:2], gap_busy,
                    rx_bit_eight_r};
                default: pslverr_r <= 1'b1;
            endcase
        end
    end

    // mode, control and mask writes; upper bits are simply not stored
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_a_r <= `SCMC_MODE_RST;
            mode_b_r <= `SCMC_MODE_RST;
            ctrl_r <= `SCMC_CTRL_RST;
            int_mask_r <= `SCMC_INT_RST;
        end else if (wr_en) begin
            if (paddr_i == `SCMC_OFF_MODE_A) mode_a_r <= pwdata_i[7:0];
            if (paddr_i == `SCMC_OFF_MODE_B) mode_b_r <= pwdata_i[7:0];
            if (paddr_i == `SCMC_OFF_CTRL) ctrl_r <= pwdata_i[2:0];
            if (paddr_i == `SCMC_OFF_INT_MASK) int_mask_r <= pwdata_i[1:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    // wakeup filters out frames with ninth bit clear, only in 9-bit mode
    assign rx_evt = rx_frame_done_i && rx_en && !(mode == SCMC_UART9
        && mode_a_r[`SCMC_A_WAKEUP] && !rx_ninth_i);
    assign tx_evt = tx_frame_done_i;
    assign w1c = (wr_en && paddr_i == `SCMC_OFF_INT_STAT)
        ? pwdata_i[1:0] : 2'h0;

    // set wins over a same-cycle clear so no event is lost
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            int_stat_r <= `SCMC_INT_RST;
        end else begin
            int_stat_r <= (int_stat_r & ~w1c) | {tx_evt, rx_evt};
        end
    end

    assign irq_o = |(int_stat_r & int_mask_r);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_mode_frame_len: assert property (
        @(posedge clock_i) disable iff (rst_i)
        mode_a_r[3:2] == 2'h1 |-> frame_bits_o == 4'h7
    ) else $error("7-bit mode frame length wrong");

    a_async_clk_src: assert property (
        @(posedge clock_i) disable iff (rst_i)
        mode_a_r[3:2] != 2'h0 && mode_a_r[1:0] == 2'h2 |-> xfer_tick_o
    ) else $error("system clock source not selected");

    a_io_clk_pin: assert property (
        @(posedge clock_i) disable iff (rst_i)
        mode_a_r[3:2] == 2'h0 && ctrl_r[0]
        |-> xfer_tick_o == (serial_clock_pin_i && !$past(serial_clock_pin_i))
    ) else $error("io mode with pin clock did not follow pin");

    a_tx_ninth_out: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $rose(tx_ninth_bit_o) |-> mode_a_r[3:2] == 2'h3 && mode_a_r[7]
    ) else $error("ninth bit sent outside 9-bit mode");

    a_cts_blocks_tx: assert property (
        @(posedge clock_i) disable iff (rst_i)
        mode_a_r[3:2] != 2'h0 && mode_a_r[6] && clear_to_send_pin_n_i
        |-> !tx_allow_o
    ) else $error("transmit allowed without clear to send");

    a_wakeup_filter: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !int_stat_r[0] && mode_a_r[3:2] == 2'h3 && mode_a_r[4]
        && rx_frame_done_i && !rx_ninth_i |=> !int_stat_r[0]
    ) else $error("wakeup let a ninth-bit-zero frame interrupt");

    a_duplex_off: assert property (
        @(posedge clock_i) disable iff (rst_i)
        mode_a_r[3:2] == 2'h0 && mode_b_r[6:5] == 2'h0
        |-> !tx_allow_o && !rx_enable_o
    ) else $error("transfer not prohibited with duplex off");

    a_fifo_setup: assert property (
        @(posedge clock_i) disable iff (rst_i)
        ctrl_r[2] |-> fifo_cfg_o == mode_b_r[6:5]
    ) else $error("fifo setup does not follow duplex field");

    a_txe_gates_tx: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $rose(tx_allow_o) |-> mode_b_r[4]
    ) else $error("transmit allowed with transmit disabled");

    a_gap_ignored: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !gap_apply |=> !gap_busy || $past(gap_apply) == 1'b0 && !gap_busy
    ) else $error("gap active outside buffered clock-out io mode");

    a_sclk_drive: assert property (
        @(posedge clock_i) disable iff (rst_i)
        serial_clock_pin_oe_o |-> mode_a_r[3:2] == 2'h0 && !ctrl_r[0]
    ) else $error("serial clock driven outside io clock-out mode");

    a_rx_bit_eight: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rx_frame_done_i && mode_a_r[3:2] == 2'h3
        |=> rx_bit_eight_r == $past(rx_ninth_i)
    ) else $error("received ninth bit not captured");

    a_upper_zero: assert property (
        @(posedge clock_i) disable iff (rst_i)
        psel_i && penable_i && !pwrite_i
        && (paddr_i == `SCMC_OFF_MODE_A || paddr_i == `SCMC_OFF_MODE_B)
        |-> prdata_o[31:8] == 24'h00_0000
    ) else $error("mode register upper bits not zero");

    a_irq_level: assert property (
        @(posedge clock_i) disable iff (rst_i)
        irq_o |-> ##0 (int_stat_r & int_mask_r) != 2'h0
    ) else $error("interrupt high with no unmasked status");

endmodule

// *** scmc_cfg.svh ***
// register offsets, field positions and reset values of the serial mode control
`ifndef SCMC_CFG_SVH
`define SCMC_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SCMC_OFF_MODE_A 8'h00
`define SCMC_OFF_MODE_B 8'h04
`define SCMC_OFF_INT_STAT 8'h08
`define SCMC_OFF_INT_MASK 8'h0c
`define SCMC_OFF_CTRL 8'h10
`define SCMC_OFF_STAT 8'h14

// ----------------------------------------------------------------------
// serial_mode_control_a fields
// ----------------------------------------------------------------------
`define SCMC_A_TX_NINTH 7
`define SCMC_A_HS_EN 6
`define SCMC_A_RX_EN 5
`define SCMC_A_WAKEUP 4
`define SCMC_A_MODE_HI 3
`define SCMC_A_MODE_LO 2
`define SCMC_A_CSRC_HI 1
`define SCMC_A_CSRC_LO 0

// ----------------------------------------------------------------------
// serial_mode_control_b fields
// ----------------------------------------------------------------------
`define SCMC_B_DPX_HI 6
`define SCMC_B_DPX_LO 5
`define SCMC_B_TX_EN 4
`define SCMC_B_GAP_HI 3
`define SCMC_B_GAP_LO 1

// ----------------------------------------------------------------------
// control, status and interrupt fields
// ----------------------------------------------------------------------
`define SCMC_C_CLK_DIR 0
`define SCMC_C_DBUF_EN 1
`define SCMC_C_FIFO_EN 2
`define SCMC_S_RX_BIT8 0
`define SCMC_S_GAP_BUSY 1
`define SCMC_I_RX 0
`define SCMC_I_TX 1

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define SCMC_MODE_RST 8'h00
`define SCMC_CTRL_RST 3'h0
`define SCMC_INT_RST 2'h0
`define SCMC_GAP_CNT_W 7

`endif

// *** scmc_pkg.sv ***
// types shared by the serial mode control block
package scmc_pkg;

    // transfer mode, in field order 00..11
    typedef enum logic [1:0] {
        SCMC_IO,
        SCMC_UART7,
        SCMC_UART8,
        SCMC_UART9
    } scmc_mode_t;

    // asynchronous clock source, in field order 00..11
    typedef enum logic [1:0] {
        SCMC_CLK_TIMER,
        SCMC_CLK_BAUD,
        SCMC_CLK_SYS,
        SCMC_CLK_PIN
    } scmc_clk_src_t;

    // duplex field, in field order 00..11
    typedef enum logic [1:0] {
        SCMC_DPX_OFF,
        SCMC_DPX_RX,
        SCMC_DPX_TX,
        SCMC_DPX_FULL
    } scmc_duplex_t;

    // gap timer states
    typedef enum logic {
        SCMC_GAP_IDLE,
        SCMC_GAP_WAIT
    } scmc_gap_state_t;

endpackage

// *** scmc_gap_timer.sv ***
// gap timer between back-to-back synchronous transmissions
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_gap_timer
    import scmc_pkg::*;
(
    input wire logic clock_i, // system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic enable_i, // gap applies in current mode
    input wire logic start_i, // a transmission just ended
    input wire logic tick_i, // one serial clock cycle
    input wire logic [2:0] interval_i, // gap code
    output logic busy_o // gap in progress
);

    // ------------------------------------------------------------------
    // gap length
    // ------------------------------------------------------------------
    function automatic logic [`SCMC_GAP_CNT_W-1:0] gap_len(
        input logic [2:0] code
    );
        gap_len = (`SCMC_GAP_CNT_W)'(1) << (code - 3'h1);
    endfunction

    scmc_gap_state_t state_r;
    logic [`SCMC_GAP_CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------------
    // state and counter
    // ------------------------------------------------------------------
    // dropping enable aborts a gap so a mode change never leaves tx stuck
    always_ff @(posedge clock_i) begin
        if (rst_i || !enable_i) begin
            state_r <= SCMC_GAP_IDLE;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                SCMC_GAP_IDLE: begin
                    if (start_i && interval_i != 3'h0) begin
                        state_r <= SCMC_GAP_WAIT;
                        cnt_r <= gap_len(interval_i);
                    end
                end
                SCMC_GAP_WAIT: begin
                    if (tick_i) begin
                        cnt_r <= cnt_r - (`SCMC_GAP_CNT_W)'(1);
                        if (cnt_r == (`SCMC_GAP_CNT_W)'(1)) begin
                            state_r <= SCMC_GAP_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign busy_o = (state_r == SCMC_GAP_WAIT);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_gap_one_tick: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!busy_o && enable_i && start_i && interval_i == 3'h1)
        ##1 (enable_i && tick_i) |=> !busy_o
    ) else $error("one-cycle gap did not end after one tick");

    a_gap_len_seven: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!busy_o && enable_i && start_i && interval_i == 3'h7)
        |=> busy_o && cnt_r == 7'h40
    ) else $error("gap code 7 did not load 64 cycles");

endmodule

// *** scmc_peer.sv ***
// external serial peer: handshake line and received-frame events
`timescale 1ns/1ps

module scmc_peer (
    input wire logic clock_i, // system clock
    input wire logic ready_i, // peer can take data
    input wire logic send_i, // deliver one frame
    input wire logic ninth_i, // ninth bit of that frame
    output logic cts_n_o, // clear to send, low active
    output logic rx_done_o, // frame received pulse
    output logic rx_ninth_o // ninth bit of the frame
);
    // ----------------------------------------------------------------
    // peer behaviour
    // ----------------------------------------------------------------
    // the ninth bit is only meaningful with the pulse, so it flips after
    always_ff @(posedge clock_i) begin
        cts_n_o <= !ready_i;
        rx_done_o <= send_i;
        rx_ninth_o <= send_i ? ninth_i : !rx_ninth_o;
    end
endmodule

// *** scmc_top_test.sv ***
// self-checking bench for the serial mode control block
`timescale 1ns/1ps
`include "scmc_cfg.svh"

module scmc_top_test;
    import scmc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, perr, prdy;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, prd, got;
    logic tmr = 0, baud = 0, rdy = 0, snd = 0, nin = 0, txd = 0, pin = 0;
    logic cts_n, rxd, rxn, tick, t9, txa, receive_enable, irq, sclk, oe, err;
    logic [3:0] bits;
    logic [1:0] fifo;
    int bad_count = 0, n_compared = 0, c, k;

    scmc_top scmc_top_inst (.clock_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .timer_output_i(tmr), .baud_tick_i(baud),
        .serial_clock_pin_i(pin), .serial_clock_pin_o(sclk),
        .serial_clock_pin_oe_o(oe), .clear_to_send_pin_n_i(cts_n),
        .rx_frame_done_i(rxd), .rx_ninth_i(rxn), .tx_frame_done_i(txd),
        .xfer_tick_o(tick), .frame_bits_o(bits), .tx_ninth_bit_o(t9),
        .tx_allow_o(txa), .rx_enable_o(receive_enable), .fifo_cfg_o(fifo),
        .irq_o(irq));
    scmc_peer scmc_peer_inst (.clock_i(clk), .ready_i(rdy), .send_i(snd),
        .ninth_i(nin), .cts_n_o(cts_n), .rx_done_o(rxd),
        .rx_ninth_o(rxn));

    // ----------------------------------------------------------------
    // bus master and compare helpers
    // ----------------------------------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // request held until pready is seen, never a fixed latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        got = prd;
        err = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // enables go last; nothing is in flight while they drop
    task setup(input logic [31:0] cr, input logic [31:0] a,
            input logic [31:0] b);
        wr(`SCMC_OFF_CTRL, cr);
        wr(`SCMC_OFF_MODE_A, a & 32'h0000_00df);
        wr(`SCMC_OFF_MODE_B, b & 32'h0000_00ef);
        wr(`SCMC_OFF_MODE_A, a);
        wr(`SCMC_OFF_MODE_B, b);
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task frame(input logic n);
        @(posedge clk);
        snd <= 1;
        nin <= n;
        @(posedge clk);
        snd <= 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    // generous bound of 25000 cycles, the sequence needs under two thousand cycles
    initial begin
        #1_000_000;
        bad_count++;
        summarize;
    end
    initial begin
        void'($urandom(89));
        repeat (5) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        chk({irq, txa, receive_enable, oe, bits}, 32'h18);
        apb(1'b0, `SCMC_OFF_MODE_A, 0);
        chk(got, 0);
        wr(`SCMC_OFF_MODE_A, 32'hffff_ffff);
        apb(1'b0, `SCMC_OFF_MODE_A, 0);
        chk(got, 32'hff);
        wr(`SCMC_OFF_MODE_B, 32'hffff_fffe);
        apb(1'b0, `SCMC_OFF_MODE_B, 0);
        chk(got, 32'hfe);
        apb(1'b0, 8'h1c, 0);
        chk(err, 1);
        chk(got, 0);
        // frame width and ninth bit per mode
        for (int m = 0; m < 4; m++) begin
            setup(0, 32'h80 | (m << 2), 0);
            chk(bits, (m == 0) ? 8 : 6 + m);
            chk(t9, m == 3);
        end
        // async clock sources; the pin source ticks on a rising pin edge
        for (int s = 0; s < 4; s++) begin
            setup(0, 32'h28 | s, 0);
            repeat (6) begin
                @(posedge clk);
                k = pin;
                tmr <= 1'($urandom);
                baud <= 1'($urandom);
                pin <= 1'($urandom);
                @(negedge clk);
                c = (s == 3) ? (pin & !k) : (s == 2);
                chk(tick, s == 0 ? tmr : s == 1 ? baud : c);
            end
        end
        setup(1, 32'h22, 0);
        chk({oe, tick}, 0);
        @(posedge clk);
        pin <= 0;
        @(posedge clk);
        pin <= 1;
        @(negedge clk);
        chk(tick, 1);
        setup(0, 32'h22, 0);
        chk(oe, 1);
        // driven clock flips once for every baud tick
        @(posedge clk);
        baud <= 1;
        @(negedge clk);
        k = sclk;
        @(negedge clk);
        chk(sclk, !k);
        // handshake, transmit enable and readiness in every combination
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rdy <= i[1];
            setup(0, 32'h08 | (i[0] << 6), i[2] << 4);
            chk(txa, i[2] & (!i[0] | i[1]));
        end
        // duplex field in io and async modes with the fifo on
        for (int i = 0; i < 8; i++) begin
            setup(4, 32'h20 | (i[2] << 3), 32'h10 | (i[1:0] << 5));
            chk(txa, i[2] | i[1]);
            chk(receive_enable, i[2] | i[0]);
            chk(fifo, i[1:0]);
        end
        // wake-up filter, ninth bit capture, mask and clear
        setup(0, 32'h3c, 0);
        wr(`SCMC_OFF_INT_MASK, 1);
        frame(0);
        chk(irq, 0);
        frame(1);
        chk(irq, 1);
        apb(1'b0, `SCMC_OFF_STAT, 0);
        chk(got, 32'hd);
        wr(`SCMC_OFF_INT_STAT, 1);
        wr(`SCMC_OFF_INT_MASK, 0);
        frame(1);
        chk(irq, 0);
        setup(0, 32'h38, 0);
        wr(`SCMC_OFF_INT_STAT, 1);
        frame(0);
        apb(1'b0, `SCMC_OFF_INT_STAT, 0);
        chk(got, 1);
        // gap codes, then clock input and unbuffered cases that skip it
        for (int i = 0; i < 9; i++) begin
            setup(i == 7 ? 3 : i == 8 ? 0 : 2, 0,
                32'h50 | ((i < 7 ? i + 1 : 1) << 1));
            @(posedge clk);
            txd <= 1;
            baud <= 0;
            @(posedge clk);
            txd <= 0;
            c = 0;
            for (k = 0; k < 3000; k++) begin
                @(negedge clk);
                if (txa === 1'b1) break;
                if (tick === 1'b1) c++;
                @(posedge clk);
                baud <= 1'($urandom);
            end
            chk(c, i < 7 ? 1 << i : 0);
        end
        summarize;
    end
endmodule
